// file: erd_mem_model.sv
// system memory partner: word store with prompt or random-wait answers
`timescale 1ns/1ns
module erd_mem_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic        memReq,
    input  wire logic        memWe,
    input  wire logic        memByte,
    input  wire logic [31:0] memAddr,
    input  wire logic [31:0] memWdata,
    output logic             memAck,
    output logic [31:0]      memRdata
);
    logic [31:0] mem [logic [31:0]];
    int          waitCnt;
    initial
    begin
        memAck = 1'b0;
        memRdata = 32'h0;
        waitCnt = 0;
    end
    // answer mid-cycle; read data flips except on a read answer so nothing stale survives
    always @(negedge clk)
    begin
        memAck = 1'b0;
        memRdata = ~memRdata;
        if (!rst && memReq)
        begin
            if (waitCnt > 0)
                waitCnt--;
            else
            begin
                memAck = 1'b1;
                if (!memWe)
                    memRdata = mem.exists(memAddr) ? mem[memAddr] : 32'h0;
            end
        end
    end
    always @(posedge clk)
    begin
        if (memReq && memAck)
        begin
            if (memWe && !memByte)
                mem[memAddr] = memWdata;
            waitCnt = slow ? $urandom % 4 : 0;
        end
    end
endmodule // erd_mem_model

// file: erd_pkg.sv
// shared constants, types and state layout for the receive descriptor dma
package erd_pkg;

    // ----------------------------------------------------------------
    // descriptor layout
    // ----------------------------------------------------------------
    localparam logic [31:0] ERD_STAT_WORD_OFS = 32'h0000_0000;
    localparam logic [31:0] ERD_LEN_WORD_OFS  = 32'h0000_0004;
    localparam logic [31:0] ERD_PTR_WORD_OFS  = 32'h0000_0008;
    localparam int          ERD_ACTIVE_BIT    = 31;
    localparam int          ERD_WRAP_BIT      = 30;
    localparam int          ERD_FPH_BIT       = 29;
    localparam int          ERD_FPL_BIT       = 28;
    localparam int          ERD_ERR_BIT       = 27;
    localparam int          ERD_STATUS_ERR    = 0;
    localparam int          ERD_BUFLEN_LSB    = 16;

    // descriptor step chosen by the two length select bits
    localparam logic [31:0] ERD_STEP_SEL0     = 32'h0000_0010;
    localparam logic [31:0] ERD_STEP_SEL1     = 32'h0000_0020;
    localparam logic [31:0] ERD_STEP_SEL2     = 32'h0000_0040;
    localparam logic [31:0] ERD_STEP_SEL3     = 32'h0000_0080;

    // ----------------------------------------------------------------
    // receive stream buffering
    // ----------------------------------------------------------------
    localparam int          ERD_FIFO_DEPTH    = 8;
    localparam int          ERD_RX_WORD_W     = 10;

    typedef struct packed {
        logic       last;
        logic       err;
        logic [7:0] data;
    } erd_rx_word_s;

    // ----------------------------------------------------------------
    // engine state
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE, ST_RD_STAT, ST_RD_LEN, ST_RD_PTR, ST_STANDBY,
        ST_WR_DATA, ST_WB_LEN, ST_WB_STAT
    } erd_state_e;

    typedef struct packed {
        erd_state_e  st;
        logic        req;
        logic        fresh;
        logic        firstPart;
        logic [31:0] curAddr;
        logic [31:0] status;
        logic [15:0] bufLen;
        logic [31:0] bufPtr;
        logic [15:0] count;
        logic        endFrame;
        logic        errFrame;
        logic        memReq;
        logic        memWe;
        logic        memByte;
        logic [31:0] memAddr;
        logic [31:0] memWdata;
        logic        frameEvt;
    } erd_dma_s;

endpackage

// file: erd_rx_dma.sv
// receive descriptor dma engine with its receive stream fifo
//
// Functional notes
// - start only while mac receive enable is high and request bit set
// - after soft reset first descriptor comes from list base; standby if active
// - inactive descriptor found: clear request bit and stop
// - active descriptor: store fifo data into buffer at pointer word address
// - buffer full mid-frame: write back position 10 or 00, fetch next
// - frame end or error abort: write back position 11 or 01
// - continuous mode: after frame write-back fetch next descriptor, standby if active
// - single mode: after frame write-back clear request bit and halt
// - request set again: resume at descriptor after last used
// - wrap flag set: next fetch returns to list base
// - frame error reported at status bit 27, zero means good
// - only frame contents without preamble, delimiter and crc reach the buffer
// - descriptor padding is never read nor written
// - descriptor words: status, length, pointer, then padding
// - frame done: clear active flag and record result in status bits
// - descriptors stepped by length chosen with the select bits
`timescale 1ns/1ns

module erd_rx_fifo #(
    parameter int W = 10,
    parameter int D = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         inValid,
    input  wire logic [W-1:0] inData,
    output logic              inReady,
    output logic              outValid,
    output logic [W-1:0]      outData,
    input  wire logic         outReady
);
    import erd_pkg::*;

    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
        logic                full;
        logic                empty;
        logic                ready;
    } erd_fifo_s;

    erd_fifo_s fifo_reg;
    erd_fifo_s fifo_next;
    logic      push;
    logic      pop;

    assign push     = inValid && !fifo_reg.full;
    assign pop      = outReady && !fifo_reg.empty;
    assign inReady  = fifo_reg.ready;
    assign outValid = !fifo_reg.empty;
    assign outData  = fifo_reg.mem[fifo_reg.rp];

    always_comb
    begin
        fifo_next = fifo_reg;
        if (push)
        begin
            fifo_next.mem[fifo_reg.wp] = inData;
            fifo_next.wp               = AW'(fifo_reg.wp + 1'b1);
        end
        if (pop)
        begin
            fifo_next.rp = AW'(fifo_reg.rp + 1'b1);
        end
        if (push && !pop)
        begin
            fifo_next.cnt = (AW+1)'(fifo_reg.cnt + 1'b1);
        end
        else if (pop && !push)
        begin
            fifo_next.cnt = (AW+1)'(fifo_reg.cnt - 1'b1);
        end
        fifo_next.full  = (fifo_next.cnt == (AW+1)'(D));
        fifo_next.empty = (fifo_next.cnt == '0);
        // registered so the stream ready leaves straight from a flop
        fifo_next.ready = !fifo_next.full;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fifo_reg       <= '0;
            fifo_reg.empty <= 1'b1;
            fifo_reg.ready <= 1'b1;
        end
        else
        begin
            fifo_reg <= fifo_next;
        end
    end

endmodule // erd_rx_fifo

module erd_rx_dma (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 softReset,
    input  wire logic                 macRxEnable,
    input  wire logic                 rxDmaRequestSet,
    input  wire logic                 continuousRxControl,
    input  wire logic [1:0]           descLengthSel,
    input  wire logic [31:0]          descListBase,
    input  wire logic                 rxValid,
    input  wire erd_pkg::erd_rx_word_s rxWord,
    output logic                      rxReady,
    output logic                      memReq,
    output logic                      memWe,
    output logic                      memByte,
    output logic [31:0]               memAddr,
    output logic [31:0]               memWdata,
    input  wire logic                 memAck,
    input  wire logic [31:0]          memRdata,
    output logic                      rxDmaRequest,
    output logic                      frameReceivedEvent
);
    import erd_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] desc_step(input logic [1:0] sel);
        case (sel)
            2'h0:    desc_step = ERD_STEP_SEL0;
            2'h1:    desc_step = ERD_STEP_SEL1;
            2'h2:    desc_step = ERD_STEP_SEL2;
            default: desc_step = ERD_STEP_SEL3;
        endcase
    endfunction

    function automatic logic [31:0] add32(input logic [31:0] a, input logic [31:0] b);
        add32 = 32'(a + b);
    endfunction

    // ----------------------------------------------------------------
    // receive stream fifo
    // ----------------------------------------------------------------
    erd_dma_s     dma_reg;
    erd_dma_s     dma_next;
    logic         fifoValid;
    logic         fifoPop;
    erd_rx_word_s fifoWord;
    logic         inReadyNet;
    logic [15:0]  countInc;
    logic [31:0]  nextDesc;

    erd_rx_fifo #(
        .W (ERD_RX_WORD_W),
        .D (ERD_FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst      (rst),
        .inValid  (rxValid),
        .inData   (rxWord),
        .inReady  (inReadyNet),
        .outValid (fifoValid),
        .outData  (fifoWord),
        .outReady (fifoPop)
    );

    // fifo ready is itself a flop output inside the fifo
    assign rxReady            = inReadyNet;
    assign fifoPop            = (dma_reg.st == ST_STANDBY) && fifoValid;
    assign countInc           = 16'(dma_reg.count + 1'b1);
    assign memReq             = dma_reg.memReq;
    assign memWe              = dma_reg.memWe;
    assign memByte            = dma_reg.memByte;
    assign memAddr            = dma_reg.memAddr;
    assign memWdata           = dma_reg.memWdata;
    assign rxDmaRequest       = dma_reg.req;
    assign frameReceivedEvent = dma_reg.frameEvt;

    // wrap returns to list base instead of the contiguous step
    assign nextDesc = dma_reg.status[ERD_WRAP_BIT] ? descListBase
                    : add32(dma_reg.curAddr, desc_step(descLengthSel));

    // ----------------------------------------------------------------
    // engine
    // ----------------------------------------------------------------
    always_comb
    begin
        dma_next          = dma_reg;
        dma_next.frameEvt = 1'b0;
        case (dma_reg.st)
            ST_IDLE:
            begin
                if (dma_reg.req && macRxEnable)
                begin
                    // first start after soft reset uses the list base
                    dma_next.curAddr  = dma_reg.fresh ? descListBase
                                      : dma_reg.curAddr;
                    dma_next.fresh    = 1'b0;
                    dma_next.memReq   = 1'b1;
                    dma_next.memWe    = 1'b0;
                    dma_next.memByte  = 1'b0;
                    dma_next.memAddr  = dma_reg.fresh ? descListBase : dma_reg.curAddr;
                    dma_next.st       = ST_RD_STAT;
                end
            end
            ST_RD_STAT:
            begin
                if (memAck)
                begin
                    dma_next.status = memRdata;
                    if (!memRdata[ERD_ACTIVE_BIT])
                    begin
                        // position kept so a new request retries this descriptor
                        dma_next.req    = 1'b0;
                        dma_next.memReq = 1'b0;
                        dma_next.st     = ST_IDLE;
                    end
                    else
                    begin
                        dma_next.memAddr = add32(dma_reg.curAddr, ERD_LEN_WORD_OFS);
                        dma_next.st      = ST_RD_LEN;
                    end
                end
            end
            ST_RD_LEN:
            begin
                if (memAck)
                begin
                    dma_next.bufLen  = memRdata[ERD_BUFLEN_LSB +: 16];
                    dma_next.memAddr = add32(dma_reg.curAddr, ERD_PTR_WORD_OFS);
                    dma_next.st      = ST_RD_PTR;
                end
            end
            ST_RD_PTR:
            begin
                if (memAck)
                begin
                    // padding beyond the pointer word is never fetched
                    dma_next.bufPtr = memRdata;
                    dma_next.count  = '0;
                    dma_next.memReq = 1'b0;
                    dma_next.st     = ST_STANDBY;
                end
            end
            ST_STANDBY:
            begin
                if (fifoValid)
                begin
                    // mac stream already stripped of preamble, delimiter and crc
                    dma_next.endFrame = fifoWord.last;
                    dma_next.errFrame = fifoWord.err;
                    dma_next.memReq   = 1'b1;
                    dma_next.memWe    = 1'b1;
                    dma_next.memByte  = 1'b1;
                    dma_next.memAddr  = add32(dma_reg.bufPtr, {16'h0000, dma_reg.count});
                    dma_next.memWdata = {24'h000000, fifoWord.data};
                    dma_next.st       = ST_WR_DATA;
                end
            end
            ST_WR_DATA:
            begin
                if (memAck)
                begin
                    dma_next.count = countInc;
                    if (dma_reg.endFrame || (countInc == dma_reg.bufLen))
                    begin
                        dma_next.memByte  = 1'b0;
                        dma_next.memAddr  = add32(dma_reg.curAddr, ERD_LEN_WORD_OFS);
                        dma_next.memWdata = {dma_reg.bufLen, countInc};
                        dma_next.st       = ST_WB_LEN;
                    end
                    else
                    begin
                        dma_next.memReq = 1'b0;
                        dma_next.st     = ST_STANDBY;
                    end
                end
            end
            ST_WB_LEN:
            begin
                if (memAck)
                begin
                    // status written last so software sees a complete descriptor
                    dma_next.memAddr                  = add32(dma_reg.curAddr,
                                                              ERD_STAT_WORD_OFS);
                    dma_next.memWdata                 = '0;
                    dma_next.memWdata[ERD_ACTIVE_BIT] = 1'b0;
                    dma_next.memWdata[ERD_WRAP_BIT]   = dma_reg.status[ERD_WRAP_BIT];
                    dma_next.memWdata[ERD_FPH_BIT]    = dma_reg.firstPart;
                    dma_next.memWdata[ERD_FPL_BIT]    = dma_reg.endFrame;
                    dma_next.memWdata[ERD_ERR_BIT]    = dma_reg.errFrame;
                    dma_next.memWdata[ERD_STATUS_ERR] = dma_reg.errFrame;
                    dma_next.st                       = ST_WB_STAT;
                end
            end
            ST_WB_STAT:
            begin
                if (memAck)
                begin
                    dma_next.frameEvt  = dma_reg.endFrame;
                    dma_next.firstPart = dma_reg.endFrame;
                    dma_next.curAddr   = nextDesc;
                    if (dma_reg.endFrame && !continuousRxControl)
                    begin
                        dma_next.req    = 1'b0;
                        dma_next.memReq = 1'b0;
                        dma_next.st     = ST_IDLE;
                    end
                    else
                    begin
                        dma_next.memWe   = 1'b0;
                        dma_next.memAddr = nextDesc;
                        dma_next.st      = ST_RD_STAT;
                    end
                end
            end
            default:
            begin
                dma_next.memReq = 1'b0;
                dma_next.st     = ST_IDLE;
            end
        endcase

        // soft reset abandons any bus access; the next start uses the base
        if (softReset)
        begin
            dma_next.st        = ST_IDLE;
            dma_next.req       = 1'b0;
            dma_next.fresh     = 1'b1;
            dma_next.firstPart = 1'b1;
            dma_next.memReq    = 1'b0;
            dma_next.memWe     = 1'b0;
        end

        // a software set in the same cycle as a hardware clear wins
        if (rxDmaRequestSet)
        begin
            dma_next.req = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dma_reg           <= '0;
            dma_reg.st        <= ST_IDLE;
            dma_reg.fresh     <= 1'b1;
            dma_reg.firstPart <= 1'b1;
        end
        else
        begin
            dma_reg <= dma_next;
        end
    end

endmodule // erd_rx_dma

// file: erd_rx_dma_properties.sv
// port assertions for the receive descriptor dma engine
`timescale 1ns/1ns
module erd_rx_dma_properties
    import erd_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  softReset,
    input wire logic                  macRxEnable,
    input wire logic                  rxDmaRequestSet,
    input wire logic                  continuousRxControl,
    input wire logic [1:0]            descLengthSel,
    input wire logic [31:0]           descListBase,
    input wire logic                  rxValid,
    input wire erd_pkg::erd_rx_word_s rxWord,
    input wire logic                  rxReady,
    input wire logic                  memReq,
    input wire logic                  memWe,
    input wire logic                  memByte,
    input wire logic [31:0]           memAddr,
    input wire logic [31:0]           memWdata,
    input wire logic                  memAck,
    input wire logic [31:0]           memRdata,
    input wire logic                  rxDmaRequest,
    input wire logic                  frameReceivedEvent
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------------------------------------------------------
    // descriptor read phase: 0 status, 1 length, 2 pointer
    // ----------------------------------------------------------------
    logic [1:0] rdPhaseReg;
    logic [1:0] rdPhaseNext;
    logic       rdAck;
    logic       wordWrAck;
    logic       eofWbAck;
    assign rdAck = memReq && memAck && !memWe;
    assign eofWbAck = memReq && memAck && memWe && !memByte && memWdata[ERD_FPL_BIT];
    assign wordWrAck = memReq && memAck && memWe && !memByte && !softReset;
    always_comb
    begin
        rdPhaseNext = rdPhaseReg;
        if (softReset)
            rdPhaseNext = 2'h0;
        else if (rdAck && !(rdPhaseReg == 2'h0 && !memRdata[ERD_ACTIVE_BIT]))
            rdPhaseNext = (rdPhaseReg == 2'h2) ? 2'h0 : rdPhaseReg + 2'h1;
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdPhaseReg <= 2'h0;
        else
            rdPhaseReg <= rdPhaseNext;
    end
    start_gate_a:
        assert property ($rose(memReq) |-> macRxEnable && rxDmaRequest)
        else $error("bus access began without enable and request");
    bus_hold_a:
        assert property (memReq && !memAck && !softReset |=> memReq && $stable(memAddr)
            && $stable(memWe) && $stable(memByte) && $stable(memWdata))
        else $error("bus request changed before acknowledge");
    desc_step_a:
        assert property (rdAck && !softReset ##1 memReq && !memWe
            |-> memAddr == $past(memAddr) + 32'h4)
        else $error("descriptor words not read in order");
    wb_order_a:
        assert property (wordWrAck ##1 memReq && memWe
            |-> !memByte && memAddr == $past(memAddr) - 32'h4)
        else $error("status write does not follow length write");
    wb_status_a:
        assert property (wordWrAck ##1 memReq && memWe |-> !memWdata[ERD_ACTIVE_BIT]
            && memWdata[ERD_ERR_BIT] == memWdata[0] && memWdata[26:1] == 26'h0)
        else $error("written status word malformed");
    stop_inactive_a:
        assert property (rdAck && rdPhaseReg == 2'h0 && !memRdata[ERD_ACTIVE_BIT]
            && !rxDmaRequestSet && !softReset |=> !rxDmaRequest && !memReq)
        else $error("inactive descriptor did not stop the engine");
    halt_single_a:
        assert property (frameReceivedEvent && !$past(continuousRxControl)
            && !$past(rxDmaRequestSet) |-> !rxDmaRequest && !memReq)
        else $error("single mode did not halt after frame");
    cont_fetch_a:
        assert property (frameReceivedEvent && $past(continuousRxControl)
            && !$past(softReset) |-> memReq && !memWe)
        else $error("continuous mode did not fetch next descriptor");
    event_cause_a:
        assert property (frameReceivedEvent |-> $past(eofWbAck) ##1 !frameReceivedEvent)
        else $error("frame event without end-of-frame write-back");
endmodule // erd_rx_dma_properties

bind erd_rx_dma erd_rx_dma_properties chk (
    .clk(clk), .rst(rst), .softReset(softReset), .macRxEnable(macRxEnable),
    .rxDmaRequestSet(rxDmaRequestSet), .continuousRxControl(continuousRxControl),
    .descLengthSel(descLengthSel), .descListBase(descListBase), .rxValid(rxValid),
    .rxWord(rxWord), .rxReady(rxReady), .memReq(memReq), .memWe(memWe),
    .memByte(memByte), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
    .memRdata(memRdata), .rxDmaRequest(rxDmaRequest),
    .frameReceivedEvent(frameReceivedEvent)
);

// file: test_erd_rx_dma.sv
// self-checking bench for the receive descriptor dma engine
`timescale 1ns/1ns
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin errCount++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module test_erd_rx_dma;
    import erd_pkg::*;
    localparam logic [31:0] BASE = 32'h0000_0100;
    localparam int NDESC = 4;
    typedef struct packed {logic we; logic bt; logic [31:0] a; logic [31:0] d;} erd_acc_s;
    logic clk, rst, softReset, macRxEnable, rxDmaRequestSet, continuousRxControl, slow;
    logic rxValid, rxReady, memReq, memWe, memByte, memAck, rxDmaRequest, frameReceivedEvent;
    logic [1:0] descLengthSel;
    logic [31:0] descListBase, memAddr, memWdata, memRdata, step;
    erd_rx_word_s rxWord;
    erd_rx_word_s stQ[$];
    erd_acc_s expQ[$];
    erd_acc_s e, got;
    bit act[NDESC];
    int errCount, nChecks, cycles, evtCount, evtExp, cur, dummy;
    logic took;
    erd_rx_dma dut (
        .clk(clk), .rst(rst), .softReset(softReset), .macRxEnable(macRxEnable),
        .rxDmaRequestSet(rxDmaRequestSet), .continuousRxControl(continuousRxControl),
        .descLengthSel(descLengthSel), .descListBase(descListBase), .rxValid(rxValid),
        .rxWord(rxWord), .rxReady(rxReady), .memReq(memReq), .memWe(memWe),
        .memByte(memByte), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
        .memRdata(memRdata), .rxDmaRequest(rxDmaRequest),
        .frameReceivedEvent(frameReceivedEvent));
    erd_mem_model mdl (
        .clk(clk), .rst(rst), .slow(slow), .memReq(memReq), .memWe(memWe),
        .memByte(memByte), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
        .memRdata(memRdata));
    always #10 clk = ~clk;
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic endSim();
        $display("checks %0d mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic expAcc(input logic we, bt, input logic [31:0] a, d);
        expQ.push_back('{we, bt, a, d});
    endtask
    function automatic logic [31:0] dAddr(input int i);
        return BASE + 32'(i) * step;
    endfunction
    task automatic arm(input logic [15:0] bl);
        for (int i = 0; i < NDESC; i++)
        begin
            mdl.mem[dAddr(i)] = {1'b1, i == NDESC - 1, 30'h0};
            mdl.mem[dAddr(i) + 32'h4] = {bl, 16'h0};
            mdl.mem[dAddr(i) + 32'h8] = 32'h1000 + 32'(i) * 32'h100;
            act[i] = 1'b1;
        end
    endtask
    // an inactive descriptor costs only its status read
    task automatic fetch();
        expAcc(0, 0, dAddr(cur), 32'h0);
        if (act[cur])
        begin
            expAcc(0, 0, dAddr(cur) + 32'h4, 32'h0);
            expAcc(0, 0, dAddr(cur) + 32'h8, 32'h0);
        end
    endtask
    task automatic frame(input int n, input logic [15:0] bl, input logic err);
        int k;
        int c;
        logic f;
        logic [7:0] b;
        logic [31:0] ptr;
        k = 0;
        while (k < n)
        begin
            c = (n - k < int'(bl)) ? n - k : int'(bl);
            f = (k + c == n);
            ptr = 32'h1000 + 32'(cur) * 32'h100;
            for (int j = 0; j < c; j++)
            begin
                b = 8'($urandom);
                stQ.push_back('{k + j == n - 1, (k + j == n - 1) & err, b});
                expAcc(1, 1, ptr + 32'(j), {24'h0, b});
            end
            expAcc(1, 0, dAddr(cur) + 32'h4, {bl, 16'(c)});
            expAcc(1, 0, dAddr(cur), {1'b0, cur == NDESC - 1, k == 0, f, f & err, 26'h0, f & err});
            act[cur] = 1'b0;
            evtExp += int'(f);
            k += c;
            cur = (cur == NDESC - 1) ? 0 : cur + 1;
            if (!f || continuousRxControl)
                fetch();
        end
    endtask
    task automatic request();
        rxDmaRequestSet = 1'b1;
        @(negedge clk);
        rxDmaRequestSet = 1'b0;
    endtask
    // a hang here is caught by the global cycle ceiling
    task automatic settle();
        while (expQ.size() != 0 || stQ.size() != 0 || memReq)
        begin
            @(negedge clk);
        end
        repeat (4) @(negedge clk);
        `CHK(32'(expQ.size()), 32'h0)
        `CHK(rxReady, 1'b1)
        `CHK(32'(evtCount), 32'(evtExp))
    endtask
    // ----------------------------------------------------------------
    // watchers and stream driver
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        cycles++;
        if (frameReceivedEvent)
            evtCount++;
        took = rxValid && rxReady;
        if (!rst && memReq && memAck)
        begin
            e = (expQ.size() != 0) ? expQ.pop_front() : '1;
            got = '{memWe, memWe & memByte, memAddr,
                    memWe ? (memByte ? {24'h0, memWdata[7:0]} : memWdata) : 32'h0};
            `CHK(got, e)
        end
        if (cycles == 20000)
        begin
            errCount++;
            endSim();
        end
    end
    always @(negedge clk)
    begin
        if (took)
            void'(stQ.pop_front());
        rxValid = stQ.size() != 0;
        rxWord = (stQ.size() != 0) ? stQ[0] : ~rxWord;
    end
    initial
    begin
        clk = 0; rst = 1; softReset = 0; macRxEnable = 0; rxDmaRequestSet = 0; slow = 0;
        continuousRxControl = 1; descListBase = BASE; rxValid = 0; rxWord = '0; took = 0;
        errCount = 0; nChecks = 0; cycles = 0; evtCount = 0; evtExp = 0; cur = 0;
        dummy = $urandom(76);
        descLengthSel = 2'($urandom);
        step = 32'h10 << descLengthSel;
        repeat (6) @(negedge clk);
        rst = 0;
        request();
        repeat (20) @(negedge clk);
        `CHK(memReq, 1'b0)
        softReset = 1;
        @(negedge clk);
        softReset = 0;
        $display("test enable gate done");
        macRxEnable = 1; slow = 1; arm(16'h4);
        request(); fetch();
        frame(3, 16'h4, 0);
        frame(10, 16'h4, 1);
        settle();
        `CHK(rxDmaRequest, 1'b0)
        $display("test continuous chain done");
        continuousRxControl = 0; slow = 0;
        request(); fetch(); settle();
        `CHK(rxDmaRequest, 1'b0)
        arm(16'h8);
        request(); fetch(); frame(4, 16'h8, 0); settle();
        `CHK(rxDmaRequest, 1'b0)
        request(); fetch(); frame(1, 16'h8, 1); settle();
        $display("test single mode done");
        softReset = 1;
        @(negedge clk);
        softReset = 0;
        cur = 0; continuousRxControl = 1; arm(16'h8);
        request(); fetch(); frame(2, 16'h8, 0); settle();
        `CHK(rxDmaRequest, 1'b1)
        $display("test soft reset restart done");
        endSim();
    end
endmodule // test_erd_rx_dma
